// >>> ccsb_pkg.sv
// Purpose: shared constants and types for the channel control/status byte block
// Assumes: one 8-bit command byte and one 8-bit report byte per channel
// Notes: register numbers address the per-channel parameter store
`default_nettype none

package ccsb_pkg;
	localparam int CCSB_BYTE_W = 8;
	localparam int CCSB_DATA_W = 16;
	localparam int CCSB_REG_NUM_W = 6;
	// command / report byte fields
	localparam int CCSB_MODE_BIT = 7;
	localparam int CCSB_DIR_BIT = 6;
	localparam int CCSB_ERR_BIT = 6;
	localparam int CCSB_LIM2_LSB = 4;
	localparam int CCSB_LIM1_LSB = 2;
	localparam int CCSB_OVER_BIT = 1;
	localparam int CCSB_UNDER_BIT = 0;
	// threshold compare codes
	localparam logic [1:0] CCSB_CMP_OFF = 2'h0;
	localparam logic [1:0] CCSB_CMP_LESS = 2'h1;
	localparam logic [1:0] CCSB_CMP_GREATER = 2'h2;
	localparam logic [1:0] CCSB_CMP_EQUAL = 2'h3;
	// register numbers with special behaviour
	localparam logic [5:0] CCSB_REG_RAW = 6'h00;
	localparam logic [5:0] CCSB_REG_DIAG = 6'h06;
	localparam logic [5:0] CCSB_REG_TYPE = 6'h08;
	localparam logic [5:0] CCSB_REG_OVER = 6'h15;
	localparam logic [5:0] CCSB_REG_UNDER = 6'h16;
	localparam logic [5:0] CCSB_REG_FEATURE = 6'h20;
	localparam logic [5:0] CCSB_REG_THR1 = 6'h23;
	localparam logic [5:0] CCSB_REG_THR2 = 6'h24;
	// feature register bits that enable the two threshold compares
	localparam int CCSB_FEAT_LIM1_BIT = 1;
	localparam int CCSB_FEAT_LIM2_BIT = 2;
	// values after reset
	localparam logic [15:0] CCSB_OVER_RST = 16'h0fff;
	localparam logic [15:0] CCSB_UNDER_RST = 16'h0000;
	localparam logic [15:0] CCSB_FEATURE_RST = 16'h0906;
	localparam logic [15:0] CCSB_THR_RST = 16'h0000;
	localparam logic [7:0] CCSB_REPORT_RST = 8'h00;
	localparam logic [15:0] CCSB_WORD_RST = 16'h0000;
	// bytes per channel in the image for each placement option
	localparam int CCSB_STRIDE_COMPACT = 2;
	localparam int CCSB_STRIDE_FULL = 3;
	localparam int CCSB_STRIDE_ALIGNED = 4;

	typedef enum logic [0:0] {CCSB_ST_SCAN, CCSB_ST_ACK} ccsb_state_t;
endpackage : ccsb_pkg

`default_nettype wire

// >>> ccsb_reg_mem.sv
// Purpose: parameter store holding every channel's register words
// Assumes: one address shared by write and read, read data one cycle late
// Notes: contents are not reset; only the read register is
`default_nettype none

module ccsb_reg_mem #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [2**AW];

	// storage write, kept free of reset so it maps onto ram
	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	// registered read data
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule : ccsb_reg_mem

`default_nettype wire

// >>> ccsb_limit_eval.sv
// Purpose: builds one channel's report byte for process data mode
// Assumes: unsigned compare of the sample against limits and thresholds
// Notes: purely combinational, the caller registers the result
`default_nettype none

module ccsb_limit_eval (
	input wire logic [ccsb_pkg::CCSB_DATA_W-1:0] sample_i,
	input wire logic [ccsb_pkg::CCSB_DATA_W-1:0] over_lim_i,
	input wire logic [ccsb_pkg::CCSB_DATA_W-1:0] under_lim_i,
	input wire logic [ccsb_pkg::CCSB_DATA_W-1:0] thr1_i,
	input wire logic [ccsb_pkg::CCSB_DATA_W-1:0] thr2_i,
	input wire logic [ccsb_pkg::CCSB_DATA_W-1:0] feature_i,
	input wire logic error_i,
	output logic [ccsb_pkg::CCSB_BYTE_W-1:0] report_o
);
	import ccsb_pkg::*;

	function automatic logic [1:0] ccsb_cmp(input logic [CCSB_DATA_W-1:0] v, input logic [CCSB_DATA_W-1:0] t,
		input logic en);
		if (!en) begin
			ccsb_cmp = CCSB_CMP_OFF;
		end else if (v < t) begin
			ccsb_cmp = CCSB_CMP_LESS;
		end else if (v > t) begin
			ccsb_cmp = CCSB_CMP_GREATER;
		end else begin
			ccsb_cmp = CCSB_CMP_EQUAL;
		end
	endfunction : ccsb_cmp

	// bit 7 stays low as the process data acknowledgement
	always_comb begin
		report_o = '0;
		report_o[CCSB_MODE_BIT] = 1'b0;
		report_o[CCSB_ERR_BIT] = error_i;
		report_o[CCSB_LIM2_LSB +: 2] = ccsb_cmp(sample_i, thr2_i, feature_i[CCSB_FEAT_LIM2_BIT]);
		report_o[CCSB_LIM1_LSB +: 2] = ccsb_cmp(sample_i, thr1_i, feature_i[CCSB_FEAT_LIM1_BIT]);
		report_o[CCSB_OVER_BIT] = (sample_i > over_lim_i);
		report_o[CCSB_UNDER_BIT] = (sample_i < under_lim_i);
	end
endmodule : ccsb_limit_eval

`default_nettype wire

// >>> ccsb_channel_bytes.sv
// Purpose: per-channel command/report byte handling and process image placement
// Assumes: image inputs and samples are synchronous to CLK_I; placement straps are static
// Notes: channels are served in turn, one register access at a time
`default_nettype none

module ccsb_channel_bytes #(
	parameter int NUM_CH = 4,
	parameter int IMG_BYTES = 4 * NUM_CH,
	parameter logic [15:0] TYPE_CODE = 16'h0a5c // arbitrary value
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	input wire logic FULL_EVAL_I,
	input wire logic BIG_ENDIAN_I,
	input wire logic WORD_ALIGN_I,
	input wire logic [NUM_CH*ccsb_pkg::CCSB_DATA_W-1:0] SAMPLE_I,
	input wire logic [NUM_CH-1:0] ERROR_I,
	input wire logic [IMG_BYTES*ccsb_pkg::CCSB_BYTE_W-1:0] OUT_IMAGE_I,
	output logic [IMG_BYTES*ccsb_pkg::CCSB_BYTE_W-1:0] IN_IMAGE_O,
	output logic [IMG_BYTES-1:0] IN_OCCUPIED_O
);
	import ccsb_pkg::*;

	localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
	localparam int AW = CH_W + CCSB_REG_NUM_W;

	logic [CCSB_BYTE_W-1:0] cmd_byte [NUM_CH];
	logic [CCSB_DATA_W-1:0] out_word [NUM_CH];
	logic [CCSB_BYTE_W-1:0] proc_report [NUM_CH];
	logic [NUM_CH-1:0] req_pending;
	// report bytes are declared here because the request decode compares against them
	logic [CCSB_BYTE_W-1:0] report_reg [NUM_CH];
	logic [CCSB_BYTE_W-1:0] report_next [NUM_CH];
	int stride;
	int data_ofs;

	////////////////////////////////////////////////////////////////////////////
	// placement geometry shared by decode and packing
	always_comb begin
		if (!FULL_EVAL_I) begin
			stride = CCSB_STRIDE_COMPACT;
			data_ofs = 0;
		end else if (WORD_ALIGN_I) begin
			stride = CCSB_STRIDE_ALIGNED;
			data_ofs = 2;
		end else begin
			stride = CCSB_STRIDE_FULL;
			data_ofs = 1;
		end
	end

	// output image decode; compact placement has no command bytes, so
	// every channel then stays in process data mode
	always_comb begin
		int base;
		logic [CCSB_BYTE_W-1:0] b0;
		logic [CCSB_BYTE_W-1:0] b1;
		base = 0;
		b0 = '0;
		b1 = '0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			base = ch * stride;
			b0 = OUT_IMAGE_I[CCSB_BYTE_W*(base+data_ofs) +: CCSB_BYTE_W];
			b1 = OUT_IMAGE_I[CCSB_BYTE_W*(base+data_ofs+1) +: CCSB_BYTE_W];
			cmd_byte[ch] = FULL_EVAL_I ? OUT_IMAGE_I[CCSB_BYTE_W*base +: CCSB_BYTE_W] : '0;
			out_word[ch] = BIG_ENDIAN_I ? {b0, b1} : {b1, b0};
			// a request is open until the report byte echoes the command exactly
			req_pending[ch] = cmd_byte[ch][CCSB_MODE_BIT] && (report_reg[ch] != cmd_byte[ch]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-channel limit registers, mirrored from the parameter store
	logic [CCSB_DATA_W-1:0] over_reg [NUM_CH];
	logic [CCSB_DATA_W-1:0] over_next [NUM_CH];
	logic [CCSB_DATA_W-1:0] under_reg [NUM_CH];
	logic [CCSB_DATA_W-1:0] under_next [NUM_CH];
	logic [CCSB_DATA_W-1:0] thr1_reg [NUM_CH];
	logic [CCSB_DATA_W-1:0] thr1_next [NUM_CH];
	logic [CCSB_DATA_W-1:0] thr2_reg [NUM_CH];
	logic [CCSB_DATA_W-1:0] thr2_next [NUM_CH];
	logic [CCSB_DATA_W-1:0] feature_reg [NUM_CH];
	logic [CCSB_DATA_W-1:0] feature_next [NUM_CH];
	logic [CCSB_DATA_W-1:0] word_reg [NUM_CH];
	logic [CCSB_DATA_W-1:0] word_next [NUM_CH];

	// identical evaluator per channel
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_eval
			ccsb_limit_eval u_eval (
				.sample_i(SAMPLE_I[CCSB_DATA_W*gi +: CCSB_DATA_W]),
				.over_lim_i(over_reg[gi]),
				.under_lim_i(under_reg[gi]),
				.thr1_i(thr1_reg[gi]),
				.thr2_i(thr2_reg[gi]),
				.feature_i(feature_reg[gi]),
				.error_i(ERROR_I[gi]),
				.report_o(proc_report[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// access sequencer
	ccsb_state_t state_reg;
	ccsb_state_t state_next;
	logic [CH_W-1:0] chan_reg;
	logic [CH_W-1:0] chan_next;
	logic [CCSB_BYTE_W-1:0] req_reg;
	logic [CCSB_BYTE_W-1:0] req_next;
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [CCSB_DATA_W-1:0] mem_rdata;
	logic [CCSB_DATA_W-1:0] rd_value;
	logic [CH_W-1:0] chan_inc;

	assign chan_inc = (chan_reg == CH_W'(NUM_CH - 1)) ? '0 : chan_reg + 1'b1;

	// a write goes to the store in the scan cycle; the echo follows in the
	// ack cycle, by which time the store also has the read data registered
	always_comb begin
		state_next = state_reg;
		chan_next = chan_reg;
		req_next = req_reg;
		mem_we = 1'b0;
		mem_addr = {chan_reg, cmd_byte[chan_reg][CCSB_REG_NUM_W-1:0]};
		case (state_reg)
			CCSB_ST_SCAN: begin
				if (req_pending[chan_reg]) begin
					req_next = cmd_byte[chan_reg];
					mem_we = cmd_byte[chan_reg][CCSB_DIR_BIT];
					state_next = CCSB_ST_ACK;
				end else begin
					chan_next = chan_inc;
				end
			end
			CCSB_ST_ACK: begin
				mem_addr = {chan_reg, req_reg[CCSB_REG_NUM_W-1:0]};
				chan_next = chan_inc;
				state_next = CCSB_ST_SCAN;
			end
			default: begin
				state_next = CCSB_ST_SCAN;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_reg <= CCSB_ST_SCAN;
			chan_reg <= '0;
			req_reg <= CCSB_REPORT_RST;
		end else if (CE_I) begin
			state_reg <= state_next;
			chan_reg <= chan_next;
			req_reg <= req_next;
		end
	end

	ccsb_reg_mem #(
		.AW(AW),
		.DW(CCSB_DATA_W)
	) u_mem (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.ce_i(CE_I),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(out_word[chan_reg]),
		.rdata_o(mem_rdata)
	);

	// read value: live sample, diagnostic byte and type code bypass the store
	always_comb begin
		case (req_reg[CCSB_REG_NUM_W-1:0])
			CCSB_REG_RAW: rd_value = SAMPLE_I[CCSB_DATA_W*chan_reg +: CCSB_DATA_W];
			CCSB_REG_DIAG: rd_value = {8'h00, proc_report[chan_reg]};
			CCSB_REG_TYPE: rd_value = TYPE_CODE;
			default: rd_value = mem_rdata;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// limit mirrors follow writes so the evaluators see new values at once
	always_comb begin
		logic hit;
		hit = 1'b0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			over_next[ch] = over_reg[ch];
			under_next[ch] = under_reg[ch];
			thr1_next[ch] = thr1_reg[ch];
			thr2_next[ch] = thr2_reg[ch];
			feature_next[ch] = feature_reg[ch];
			hit = mem_we && (chan_reg == CH_W'(ch));
			if (hit) begin
				case (mem_addr[CCSB_REG_NUM_W-1:0])
					CCSB_REG_OVER: over_next[ch] = out_word[ch];
					CCSB_REG_UNDER: under_next[ch] = out_word[ch];
					CCSB_REG_THR1: thr1_next[ch] = out_word[ch];
					CCSB_REG_THR2: thr2_next[ch] = out_word[ch];
					CCSB_REG_FEATURE: feature_next[ch] = out_word[ch];
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				over_reg[ch] <= CCSB_OVER_RST;
				under_reg[ch] <= CCSB_UNDER_RST;
				thr1_reg[ch] <= CCSB_THR_RST;
				thr2_reg[ch] <= CCSB_THR_RST;
				feature_reg[ch] <= CCSB_FEATURE_RST;
			end
		end else if (CE_I) begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				over_reg[ch] <= over_next[ch];
				under_reg[ch] <= under_next[ch];
				thr1_reg[ch] <= thr1_next[ch];
				thr2_reg[ch] <= thr2_next[ch];
				feature_reg[ch] <= feature_next[ch];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// report byte and input word per channel
	always_comb begin
		logic ack;
		ack = 1'b0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			report_next[ch] = report_reg[ch];
			word_next[ch] = word_reg[ch];
			ack = (state_reg == CCSB_ST_ACK) && (chan_reg == CH_W'(ch));
			if (!cmd_byte[ch][CCSB_MODE_BIT]) begin
				// low bits of the command byte are don't-care here
				report_next[ch] = proc_report[ch];
				word_next[ch] = SAMPLE_I[CCSB_DATA_W*ch +: CCSB_DATA_W];
			end else if (ack) begin
				// echo only now, once data or store is settled
				report_next[ch] = req_reg;
				report_next[ch][CCSB_MODE_BIT] = 1'b1;
				if (!req_reg[CCSB_DIR_BIT]) begin
					word_next[ch] = rd_value;
				end
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				report_reg[ch] <= CCSB_REPORT_RST;
				word_reg[ch] <= CCSB_WORD_RST;
			end
		end else if (CE_I) begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				report_reg[ch] <= report_next[ch];
				word_reg[ch] <= word_next[ch];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input image packing; filler and unused bytes read as zero
	logic [IMG_BYTES*CCSB_BYTE_W-1:0] img_next;
	logic [IMG_BYTES-1:0] occ_next;

	always_comb begin
		int base;
		base = 0;
		img_next = '0;
		occ_next = '0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			base = ch * stride;
			if (FULL_EVAL_I) begin
				img_next[CCSB_BYTE_W*base +: CCSB_BYTE_W] = report_reg[ch];
			end
			// low and high data bytes, order set by the endian strap
			img_next[CCSB_BYTE_W*(base+data_ofs) +: CCSB_BYTE_W] =
				BIG_ENDIAN_I ? word_reg[ch][15:8] : word_reg[ch][7:0];
			img_next[CCSB_BYTE_W*(base+data_ofs+1) +: CCSB_BYTE_W] =
				BIG_ENDIAN_I ? word_reg[ch][7:0] : word_reg[ch][15:8];
		end
		// filler counts as occupied, bytes past the last channel do not
		for (int b = 0; b < IMG_BYTES; b++) begin
			occ_next[b] = (b < NUM_CH * stride);
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			IN_IMAGE_O <= '0;
			IN_OCCUPIED_O <= '0;
		end else if (CE_I) begin
			IN_IMAGE_O <= img_next;
			IN_OCCUPIED_O <= occ_next;
		end
	end
endmodule : ccsb_channel_bytes

`default_nettype wire

// >>> ccsb_dummy_unused_never.sv
`default_nettype none
`default_nettype wire

// >>> ccsb_chk.sv
// Purpose: port-level checks of the channel command/report byte block
// Assumes: straps change only under reset; channel 0 limits keep reset values
// Notes: channel 0 is the watched channel
`default_nettype none

module ccsb_chk #(
	parameter int NUM_CH = 4,
	parameter int IMG_BYTES = 16
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	input wire logic FULL_EVAL_I,
	input wire logic BIG_ENDIAN_I,
	input wire logic WORD_ALIGN_I,
	input wire logic [NUM_CH*ccsb_pkg::CCSB_DATA_W-1:0] SAMPLE_I,
	input wire logic [NUM_CH-1:0] ERROR_I,
	input wire logic [IMG_BYTES*ccsb_pkg::CCSB_BYTE_W-1:0] OUT_IMAGE_I,
	input wire logic [IMG_BYTES*ccsb_pkg::CCSB_BYTE_W-1:0] IN_IMAGE_O,
	input wire logic [IMG_BYTES-1:0] IN_OCCUPIED_O
);
	timeunit 1ns;
	timeprecision 1ps;
	import ccsb_pkg::*;
	logic [2:0] run_reg;
	logic [2:0] run_next;
	logic [IMG_BYTES-1:0] occ_exp;
	logic [15:0] w0;
	logic [15:0] s0;
	logic [15:0] sw;
	int stride;

	// cycles since reset, saturating so early $past values stay out of the checks
	always_comb begin
		run_next = (run_reg == 3'h7) ? run_reg : run_reg + 3'h1;
	end
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			run_reg <= 3'h0;
		end else begin
			run_reg <= run_next;
		end
	end

	// expected occupancy and channel 0 data word from the straps
	always_comb begin
		stride = FULL_EVAL_I ? (WORD_ALIGN_I ? 4 : 3) : 2;
		for (int k = 0; k < IMG_BYTES; k++) begin
			occ_exp[k] = (k < NUM_CH * stride);
		end
		w0 = IN_IMAGE_O[(FULL_EVAL_I ? (WORD_ALIGN_I ? 2 : 1) : 0) * 8 +: 16];
		s0 = SAMPLE_I[15:0];
		sw = BIG_ENDIAN_I ? {s0[7:0], s0[15:8]} : s0;
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	// channel 0 held in process mode with steady inputs long enough to pass the pipe
	sequence s_quiet;
		(CE_I && !OUT_IMAGE_I[7] && $stable(SAMPLE_I[15:0]) && $stable(ERROR_I[0])) [*4];
	endsequence
	// a new register request appears on channel 0
	sequence s_req;
		FULL_EVAL_I && OUT_IMAGE_I[7] && $changed(OUT_IMAGE_I[7:0]) && run_reg == 3'h7;
	endsequence

	a_occ_map: assert property (run_reg == 3'h7 |-> IN_OCCUPIED_O == occ_exp)
		else $error("occupancy map wrong");
	a_data_place: assert property (s_quiet ##0 run_reg == 3'h7 |-> w0 == sw)
		else $error("data word placement wrong");
	a_pd_ack: assert property (s_quiet ##0 run_reg == 3'h7 && FULL_EVAL_I |-> !IN_IMAGE_O[7])
		else $error("process mode ack bit wrong");
	a_error_flag: assert property (s_quiet ##0 run_reg == 3'h7 && FULL_EVAL_I |-> IN_IMAGE_O[6] == ERROR_I[0])
		else $error("error bit wrong");
	a_thr_codes: assert property (s_quiet ##0 run_reg == 3'h7 && FULL_EVAL_I
		|-> IN_IMAGE_O[5:2] == ((s0 == 16'h0000) ? 4'hf : 4'ha))
		else $error("threshold codes wrong");
	a_range_flags: assert property (s_quiet ##0 run_reg == 3'h7 && FULL_EVAL_I
		|-> IN_IMAGE_O[1:0] == {s0 > CCSB_OVER_RST, s0 < CCSB_UNDER_RST})
		else $error("range flags wrong");
	a_echo_match: assert property (s_req |-> ##[1:16] IN_IMAGE_O[7:0] == OUT_IMAGE_I[7:0])
		else $error("register echo missing");
	a_echo_late: assert property (s_req |-> (IN_IMAGE_O[7:0] != OUT_IMAGE_I[7:0]) [*3])
		else $error("register echo too early");
	a_pd_return: assert property ($fell(OUT_IMAGE_I[7]) && FULL_EVAL_I && run_reg == 3'h7
		|-> ##[1:4] !IN_IMAGE_O[7])
		else $error("process mode not resumed");
endmodule : ccsb_chk

bind ccsb_channel_bytes ccsb_chk #(.NUM_CH(NUM_CH), .IMG_BYTES(IMG_BYTES)) chk_u (.CLK_I(CLK_I),
	.RSTN_I(RSTN_I), .CE_I(CE_I), .FULL_EVAL_I(FULL_EVAL_I), .BIG_ENDIAN_I(BIG_ENDIAN_I),
	.WORD_ALIGN_I(WORD_ALIGN_I), .SAMPLE_I(SAMPLE_I), .ERROR_I(ERROR_I), .OUT_IMAGE_I(OUT_IMAGE_I),
	.IN_IMAGE_O(IN_IMAGE_O), .IN_OCCUPIED_O(IN_OCCUPIED_O));

`default_nettype wire

// >>> ccsb_ctrl_model.sv
// Purpose: controller side of the process image, command bytes and words
// Assumes: straps match those given to the block
// Notes: drives on the falling edge, polls the echo on the falling edge
`default_nettype none

module ccsb_ctrl_model #(
	parameter int NUM_CH = 4,
	parameter int IMG_BYTES = 16
) (
	input wire logic clk_i,
	input wire logic full_i,
	input wire logic big_i,
	input wire logic align_i,
	input wire logic [IMG_BYTES*8-1:0] in_image_i,
	output logic [IMG_BYTES*8-1:0] out_image_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial out_image_o = '0;

	// byte positions of a channel's command/report byte and data word
	function automatic int cbase(input int ch);
		return ch * (full_i ? (align_i ? 4 : 3) : 2);
	endfunction : cbase
	function automatic int dpos(input int ch);
		return cbase(ch) + (full_i ? (align_i ? 2 : 1) : 0);
	endfunction : dpos
	function automatic logic [7:0] rep_byte(input int ch);
		return in_image_i[cbase(ch)*8 +: 8];
	endfunction : rep_byte
	function automatic logic [15:0] data_word(input int ch);
		logic [15:0] w;
		w = in_image_i[dpos(ch)*8 +: 16];
		return big_i ? {w[7:0], w[15:8]} : w;
	endfunction : data_word

	////////////////////////////////////////////////////////////////
	// drop every command and data byte, so no request outlives a strap change
	task automatic clear_all();
		@(negedge clk_i);
		out_image_o <= '0;
	endtask : clear_all

	task automatic put_cmd(input int ch, input logic [7:0] b);
		@(negedge clk_i);
		out_image_o[cbase(ch)*8 +: 8] <= b;
	endtask : put_cmd

	// one access: pass through process mode first so a repeat is seen as new
	task automatic access(input int ch, input logic wr, input logic [5:0] num,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		logic [7:0] cmd;
		cmd = {1'b1, wr, num};
		ok = 1'b0;
		put_cmd(ch, 8'h00);
		repeat (4) @(negedge clk_i);
		out_image_o[cbase(ch)*8 +: 8] <= cmd;
		out_image_o[dpos(ch)*8 +: 16] <= big_i ? {wd[7:0], wd[15:8]} : wd;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(negedge clk_i);
			ok = (rep_byte(ch) === cmd);
		end
		rd = data_word(ch);
		out_image_o[dpos(ch)*8 +: 16] <= ~wd;
	endtask : access
endmodule : ccsb_ctrl_model

`default_nettype wire

// >>> channel_control_status_bytes_test.sv
// Purpose: self-checking bench for the channel command/report byte block
// Assumes: straps are changed only while reset is held
// Notes: channel 0 limits are never written, the checker relies on that
`default_nettype none

module channel_control_status_bytes_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ccsb_pkg::*;
	localparam logic [15:0] TYPE_VAL = 16'h5a3c; // arbitrary value
	logic clk;
	logic rstn;
	logic ce;
	logic full;
	logic big;
	logic align;
	logic [63:0] sample;
	logic [3:0] err;
	logic [127:0] out_img;
	logic [127:0] in_img;
	logic [15:0] occ;
	logic [15:0] rd_last;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;

	ccsb_channel_bytes #(.TYPE_CODE(TYPE_VAL)) dut_u (.CLK_I(clk), .RSTN_I(rstn),
		.CE_I(ce), .FULL_EVAL_I(full), .BIG_ENDIAN_I(big), .WORD_ALIGN_I(align), .SAMPLE_I(sample),
		.ERROR_I(err), .OUT_IMAGE_I(out_img), .IN_IMAGE_O(in_img), .IN_OCCUPIED_O(occ));
	ccsb_ctrl_model model_u (.clk_i(clk), .full_i(full), .big_i(big),
		.align_i(align), .in_image_i(in_img), .out_image_o(out_img));

	// 125 MHz clock and a hang limit far above the few hundred cycles needed
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// straps only move under reset, held 8 cycles
	task automatic restart(input logic f, input logic b, input logic a);
		model_u.clear_all();
		@(negedge clk);
		rstn = 1'b0;
		full = f;
		big = b;
		align = a;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
	endtask : restart

	function automatic logic [1:0] cmp(input logic on, input logic [15:0] s, input logic [15:0] t);
		if (!on) return 2'h0;
		if (s < t) return 2'h1;
		return (s > t) ? 2'h2 : 2'h3;
	endfunction : cmp

	function automatic logic [7:0] exp_rep(input logic [15:0] s, input logic e,
		input logic [15:0] ov, un, t1, t2, input logic [1:0] en);
		return {1'b0, e, cmp(en[1], s, t2), cmp(en[0], s, t1), s > ov, s < un};
	endfunction : exp_rep

	task automatic acc(input int ch, input logic wr, input logic [5:0] num, input logic [15:0] wd);
		logic ok;
		model_u.access(ch, wr, num, wd, rd_last, ok);
		chk(ok, 1'b1);
	endtask : acc

	////////////////////////////////////////////////////////////////
	// every placement option: occupancy, byte order, filler
	task automatic t_layout();
		logic [2:0] cfg [4] = '{3'b000, 3'b010, 3'b100, 3'b111};
		logic [15:0] occ_exp [4] = '{16'h00ff, 16'h00ff, 16'h0fff, 16'hffff};
		for (int i = 0; i < 4; i++) begin
			restart(cfg[i][2], cfg[i][1], cfg[i][0]);
			sample = 64'h8001_0203_4455_0a0b + i;
			repeat (2) @(negedge clk);
			chk(occ, occ_exp[i]);
			for (int c = 0; c < 4; c++) begin
				chk(model_u.data_word(c), sample[c*16 +: 16]);
			end
			if (cfg[i][0]) chk(in_img[15:8], 8'h00);
		end
	endtask : t_layout

	// process mode flags on all channels, stray command bits ignored
	task automatic t_pd_flags();
		restart(1'b1, 1'b0, 1'b0);
		model_u.put_cmd(0, 8'h7f);
		sample = {16'h0000, 16'h0fff, 16'h1000, 16'h0000};
		err = 4'h8;
		repeat (2) @(negedge clk);
		for (int c = 0; c < 4; c++) begin
			chk(model_u.rep_byte(c), exp_rep(sample[c*16 +: 16], err[c], 16'h0fff, 16'h0, 16'h0, 16'h0, 2'h3));
		end
		model_u.put_cmd(0, 8'h00);
		err = 4'h1;
		repeat (6) @(negedge clk);
	endtask : t_pd_flags

	// register writes and reads, then limits that were written take effect
	task automatic t_regs();
		logic [15:0] v [3] = '{16'h0050, 16'h0300, 16'h0100};
		restart(1'b1, 1'b0, 1'b0);
		acc(0, 1'b1, 6'h07, 16'h1234);
		acc(0, 1'b0, 6'h07, 16'h0000);
		chk(rd_last, 16'h1234);
		acc(1, 1'b1, CCSB_REG_THR1, 16'h0100);
		acc(1, 1'b1, CCSB_REG_UNDER, 16'h0080);
		acc(1, 1'b1, CCSB_REG_OVER, 16'h0200);
		acc(2, 1'b1, CCSB_REG_FEATURE, 16'h0000);
		acc(3, 1'b0, CCSB_REG_TYPE, 16'h0000);
		chk(rd_last, TYPE_VAL);
		model_u.put_cmd(1, 8'h00);
		model_u.put_cmd(2, 8'h00);
		for (int i = 0; i < 3; i++) begin
			sample[31:16] = v[i];
			sample[47:32] = v[i];
			repeat (3) @(negedge clk);
			chk(model_u.rep_byte(1), exp_rep(v[i], 1'b0, 16'h0200, 16'h0080, 16'h0100, 16'h0, 2'h3));
			chk(model_u.rep_byte(2), exp_rep(v[i], 1'b0, 16'h0fff, 16'h0000, 16'h0, 16'h0, 2'h0));
		end
		acc(2, 1'b0, CCSB_REG_RAW, 16'h0000);
		chk(rd_last, 16'h0100);
		acc(1, 1'b0, CCSB_REG_DIAG, 16'h0000);
		chk(rd_last, {8'h00, exp_rep(16'h0100, 1'b0, 16'h0200, 16'h0080, 16'h0100, 16'h0, 2'h3)});
	endtask : t_regs

	// aligned big-endian access path, then a clock-enable freeze
	task automatic t_aligned();
		restart(1'b1, 1'b1, 1'b1);
		acc(3, 1'b1, 6'h07, 16'hbeef);
		acc(3, 1'b0, 6'h07, 16'h0000);
		chk(rd_last, 16'hbeef);
		@(negedge clk);
		ce = 1'b0;
		sample[15:0] = 16'h0777;
		repeat (4) @(negedge clk);
		chk(model_u.data_word(0), 16'h0a0b);
		ce = 1'b1;
		repeat (2) @(negedge clk);
		chk(model_u.data_word(0), 16'h0777);
	endtask : t_aligned

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		full = 1'b0;
		big = 1'b0;
		align = 1'b0;
		sample = '0;
		err = '0;
		t_layout();
		t_pd_flags();
		t_regs();
		sample[15:0] = 16'h0a0b;
		t_aligned();
		end_of_test();
	end
endmodule : channel_control_status_bytes_test

`default_nettype wire
